/* File: rtl/codec_dac_load_pkg.sv */
package codec_dac_load_pkg;

  // ------------------------------------------------------------------
  // Word layout
  // ------------------------------------------------------------------
  localparam int WORD_W  = 16;
  localparam int MSB_BIT = 15;
  localparam int RB_BIT  = 14;
  localparam int ADDR_HI = 13;
  localparam int ADDR_LO = 11;
  localparam int REG_HI  = 10;
  localparam int REG_LO  = 8;
  localparam int DATA_HI = 7;

  // ------------------------------------------------------------------
  // Counts and reset values
  // ------------------------------------------------------------------
  localparam logic [4:0]  ADV_SPAN  = 5'h10;
  localparam logic [3:0]  LAST_BIT  = 4'hF;
  localparam logic [2:0]  PIN_N     = 3'h3;
  localparam logic [15:0] WORD_RST  = 16'h0000;

  // ------------------------------------------------------------------
  // State types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {TX_IDLE, TX_FS, TX_SHIFT} tx_state_t;
  typedef enum logic {RX_IDLE, RX_SHIFT} rx_state_t;

endpackage

/* File: rtl/codec_serial_rx.sv */
module codec_serial_rx
  import codec_dac_load_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_ce,
  input  wire logic        i_sclk_fall,
  input  wire logic        i_sdi,
  input  wire logic        i_ifs,
  output logic             o_word_valid,
  output logic [15:0]      o_word
);

  typedef struct packed {
    rx_state_t   st;
    logic [3:0]  cnt;
    logic [15:0] sh;
    logic        valid;
    logic [15:0] word;
  } rx_t;

  rx_t s_r;
  rx_t s_nxt;

  // ------------------------------------------------------------------
  // Frame sync then 16 bits, MSB first, on falling edges
  // ------------------------------------------------------------------
  always_comb begin
    s_nxt       = s_r;
    s_nxt.valid = 1'b0;
    if (i_sclk_fall) begin
      case (s_r.st)
        RX_IDLE: begin
          if (i_ifs) begin
            s_nxt.st  = RX_SHIFT;
            s_nxt.cnt = 4'h0;
          end
        end
        RX_SHIFT: begin
          s_nxt.sh  = {s_r.sh[14:0], i_sdi};
          s_nxt.cnt = s_r.cnt + 4'h1;
          if (s_r.cnt == LAST_BIT) begin
            s_nxt.valid = 1'b1;
            s_nxt.word  = {s_r.sh[14:0], i_sdi};
            s_nxt.st    = RX_IDLE;
          end
        end
        default: s_nxt.st = RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_r <= '0;
    end else if (i_ce) begin
      s_r <= s_nxt;
    end
  end

  assign o_word_valid = s_r.valid;
  assign o_word       = s_r.word;

endmodule // codec_serial_rx

/* File: rtl/codec_dac_load_timing.sv */
// Functional notes
// - Default DAC load just before frame sync
// - DAC load point advanced by setting
// - Frame sync marks fresh ADC sample or forwarded control word
// - Sixteen bits shifted after frame sync
// - Received DAC word held in DAC register
// - Mixed mode: MSB selects DAC or control
// - Cascade: update after device-count DAC frames
// - Later-device control: decrement, forward downstream
// - Bit 14 requests readback shifted out
module codec_dac_load_timing
  import codec_dac_load_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_ce,
  input  wire logic        i_sclk,
  input  wire logic        i_sdi,
  input  wire logic        i_input_frame_sync,
  input  wire logic        i_adc_valid,
  input  wire logic [15:0] i_adc_data,
  input  wire logic [3:0]  i_dac_advance,
  input  wire logic        i_mixed_mode,
  input  wire logic [2:0]  i_device_count,
  input  wire logic [7:0]  i_readback_data,
  output logic             o_serial_data_out,
  output logic             o_output_frame_sync,
  output logic             o_dac_load,
  output logic [15:0]      o_dac_value,
  output logic             o_ctrl_valid,
  output logic [15:0]      o_ctrl_word,
  output logic [2:0]       o_readback_sel
);

  typedef struct packed {
    logic [2:0]  sy1;
    logic [2:0]  sy2;
    logic [2:0]  sy3;
    logic [2:0]  flt;
    logic        rise;
    logic        fall;
    logic [4:0]  adc_cnt;
    logic        adv_run;
    logic        adc_pend;
    logic [15:0] adc_word;
    logic        fwd_pend;
    logic [15:0] fwd_word;
    tx_state_t   tx_st;
    logic [3:0]  tx_bits;
    logic [15:0] tx_sh;
    logic        serial_data_out;
    logic        ofs;
    logic [15:0] dac_hold;
    logic [15:0] dac_out;
    logic        dac_load;
    logic [2:0]  frm_cnt;
    logic        ctrl_valid;
    logic [15:0] ctrl_word;
  } st_t;

  st_t         s_r;
  st_t         s_nxt;
  logic        rx_valid;
  logic [15:0] rx_word;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [15:0] dec_addr(input logic [15:0] w);
    logic [2:0] a;
    a = w[ADDR_HI:ADDR_LO] - 3'h1;
    return {w[MSB_BIT:RB_BIT], a, w[REG_HI:0]};
  endfunction

  function automatic logic is_dac(input logic [15:0] w, input logic mm);
    return !mm || !w[MSB_BIT];
  endfunction

  function automatic logic [4:0] adv_point(input logic [3:0] adv);
    return {1'b0, adv} + 5'h01;
  endfunction

  // ------------------------------------------------------------------
  // Receiver
  // ------------------------------------------------------------------
  codec_serial_rx u_rx (
    .i_clk        (i_clk),
    .i_nrst       (i_nrst),
    .i_ce         (i_ce),
    .i_sclk_fall  (s_r.fall),
    .i_sdi        (s_r.flt[1]),
    .i_ifs        (s_r.flt[2]),
    .o_word_valid (rx_valid),
    .o_word       (rx_word)
  );

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    s_nxt            = s_r;
    s_nxt.dac_load   = 1'b0;
    s_nxt.ctrl_valid = 1'b0;
    s_nxt.sy1        = {i_input_frame_sync, i_sdi, i_sclk};
    s_nxt.sy2        = s_r.sy1;
    s_nxt.sy3        = s_r.sy2;
    for (int k = 0; k < int'(PIN_N); k++) begin
      if (s_r.sy2[k] == s_r.sy3[k]) begin
        s_nxt.flt[k] = s_r.sy3[k];
      end
    end
    s_nxt.rise = s_nxt.flt[0] & ~s_r.flt[0];
    s_nxt.fall = ~s_nxt.flt[0] & s_r.flt[0];

    // Transmit: driven on rising edges, host samples on falling
    case (s_r.tx_st)
      TX_IDLE: begin
        if (s_r.rise && (s_r.adc_pend || s_r.fwd_pend)) begin
          s_nxt.ofs   = 1'b1;
          s_nxt.tx_st = TX_FS;
          if (s_r.adc_pend) begin
            s_nxt.tx_sh    = s_r.adc_word;
            s_nxt.adc_pend = 1'b0;
          end else begin
            s_nxt.tx_sh    = s_r.fwd_word;
            s_nxt.fwd_pend = 1'b0;
          end
        end
      end
      TX_FS: begin
        if (s_r.rise) begin
          s_nxt.ofs     = 1'b0;
          s_nxt.serial_data_out     = s_r.tx_sh[MSB_BIT];
          s_nxt.tx_sh   = {s_r.tx_sh[14:0], 1'b0};
          s_nxt.tx_bits = 4'h0;
          s_nxt.tx_st   = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        if (s_r.rise) begin
          if (s_r.tx_bits == LAST_BIT) begin
            s_nxt.serial_data_out   = 1'b0;
            s_nxt.tx_st = TX_IDLE;
          end else begin
            s_nxt.serial_data_out     = s_r.tx_sh[MSB_BIT];
            s_nxt.tx_sh   = {s_r.tx_sh[14:0], 1'b0};
            s_nxt.tx_bits = s_r.tx_bits + 4'h1;
          end
        end
      end
      default: s_nxt.tx_st = TX_IDLE;
    endcase

    // ADC unload countdown with DAC load point inside it
    if (i_adc_valid) begin
      s_nxt.adc_word = i_adc_data;
      s_nxt.adc_cnt  = ADV_SPAN;
      s_nxt.adv_run  = 1'b1;
    end else if (s_r.adv_run) begin
      s_nxt.adc_cnt = s_r.adc_cnt - 5'h01;
      if (s_r.adc_cnt == adv_point(i_dac_advance)) begin
        s_nxt.dac_out  = s_r.dac_hold;
        s_nxt.dac_load = 1'b1;
      end
      if (s_r.adc_cnt == 5'h01) begin
        s_nxt.adv_run  = 1'b0;
        s_nxt.adc_pend = 1'b1;
      end
    end

    // Received words
    if (rx_valid) begin
      if (is_dac(rx_word, i_mixed_mode)) begin
        if (s_r.frm_cnt == i_device_count) begin
          s_nxt.dac_hold = rx_word;
          s_nxt.frm_cnt  = 3'h0;
        end else begin
          s_nxt.frm_cnt = s_r.frm_cnt + 3'h1;
        end
      end else if (rx_word[ADDR_HI:ADDR_LO] != 3'h0) begin
        s_nxt.fwd_pend = 1'b1;
        s_nxt.fwd_word = dec_addr(rx_word);
      end else if (rx_word[RB_BIT]) begin
        s_nxt.fwd_pend = 1'b1;
        s_nxt.fwd_word = dec_addr({rx_word[15:8], i_readback_data});
      end else begin
        s_nxt.ctrl_valid = 1'b1;
        s_nxt.ctrl_word  = rx_word;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_r <= '0;
    end else if (i_ce) begin
      s_r <= s_nxt;
    end
  end

  assign o_serial_data_out   = s_r.serial_data_out;
  assign o_output_frame_sync = s_r.ofs;
  assign o_dac_load          = s_r.dac_load;
  assign o_dac_value         = s_r.dac_out;
  assign o_ctrl_valid        = s_r.ctrl_valid;
  assign o_ctrl_word         = s_r.ctrl_word;
  assign o_readback_sel      = rx_word[REG_HI:REG_LO];

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst || !i_ce);

  sequence s_rx_dac;
    rx_valid && is_dac(rx_word, i_mixed_mode);
  endsequence

  sequence s_rx_ctrl;
    rx_valid && !is_dac(rx_word, i_mixed_mode);
  endsequence

  property p_load_then_fs;
    $rose(o_dac_load) |-> ##[1:400] $rose(o_output_frame_sync);
  endproperty
  a_load_then_fs: assert property (p_load_then_fs)
    else $error("no frame sync after DAC load");

  property p_adv_point;
    $rose(o_dac_load) |-> s_r.adc_cnt == {1'b0, $past(i_dac_advance)};
  endproperty
  a_adv_point: assert property (p_adv_point)
    else $error("DAC load at wrong advance");

  property p_fs_pending;
    $rose(o_output_frame_sync) |-> $past(s_r.adc_pend || s_r.fwd_pend);
  endproperty
  a_fs_pending: assert property (p_fs_pending)
    else $error("frame sync with nothing to send");

  property p_shift_len;
    $fell(o_output_frame_sync) |-> (s_r.tx_st == TX_SHIFT) [*8];
  endproperty
  a_shift_len: assert property (p_shift_len)
    else $error("shift ended early");

  property p_dac_copy;
    s_rx_dac ##0 (s_r.frm_cnt == i_device_count)
      |=> s_r.dac_hold == $past(rx_word);
  endproperty
  a_dac_copy: assert property (p_dac_copy)
    else $error("DAC register not loaded");

  property p_ctrl_keeps_dac;
    s_rx_ctrl |=> $stable(s_r.dac_hold);
  endproperty
  a_ctrl_keeps_dac: assert property (p_ctrl_keeps_dac)
    else $error("control word changed DAC register");

  property p_cascade_count;
    s_rx_dac ##0 (s_r.frm_cnt != i_device_count)
      |=> $stable(s_r.dac_hold) && s_r.frm_cnt == $past(s_r.frm_cnt) + 3'h1;
  endproperty
  a_cascade_count: assert property (p_cascade_count)
    else $error("DAC updated before count reached");

  property p_forward;
    s_rx_ctrl ##0 (rx_word[ADDR_HI:ADDR_LO] != 3'h0) |=> s_r.fwd_pend &&
      s_r.fwd_word[ADDR_HI:ADDR_LO] ==
      $past(rx_word[ADDR_HI:ADDR_LO]) - 3'h1;
  endproperty
  a_forward: assert property (p_forward)
    else $error("control word not forwarded");

  property p_readback;
    s_rx_ctrl ##0 (rx_word[ADDR_HI:ADDR_LO] == 3'h0) ##0 rx_word[RB_BIT]
      |=> s_r.fwd_pend && s_r.fwd_word[DATA_HI:0] == $past(i_readback_data);
  endproperty
  a_readback: assert property (p_readback)
    else $error("readback word not queued");

  property p_msb_first;
    s_r.tx_st == TX_FS && s_r.rise
      |=> o_serial_data_out == $past(s_r.tx_sh[15]);
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("first bit not MSB");

endmodule // codec_dac_load_timing

/* File: test/codec_dsp_port_model.sv */
module codec_dsp_port_model (
  output logic      o_sclk,
  output logic      o_sdi,
  output logic      o_ifs,
  input  wire logic i_sdo,
  input  wire logic i_ofs
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] rx_sh;
  logic [15:0] rx_word;
  int          rx_cnt;
  int          bits;

  // ------------------------------------------------------------------
  // Free-running serial clock, phase unrelated to the system clock
  // ------------------------------------------------------------------
  initial begin
    o_sclk = 1'b0;
    o_sdi = 1'b0;
    o_ifs = 1'b0;
    rx_sh = 16'h0000;
    rx_word = 16'h0000;
    rx_cnt = 0;
    bits = 0;
    #7;
    forever #160 o_sclk = ~o_sclk;
  end

  // ------------------------------------------------------------------
  // Receive: frame sync seen on a fall, then 16 falls MSB first
  // ------------------------------------------------------------------
  always @(negedge o_sclk) begin
    if (bits > 0) begin
      rx_sh = {rx_sh[14:0], i_sdo};
      bits--;
      if (bits == 0) begin
        rx_word = rx_sh;
        rx_cnt++;
      end
    end else if (i_ofs === 1'b1) begin
      bits = 16;
    end
  end

  // Send one word; data line shows the inverse level once released
  task automatic send(input logic [15:0] w);
    @(posedge o_sclk);
    o_ifs <= 1'b1;
    for (int i = 15; i >= 0; i--) begin
      @(posedge o_sclk);
      o_ifs <= 1'b0;
      o_sdi <= w[i];
    end
    @(posedge o_sclk);
    o_sdi <= ~w[0];
  endtask
endmodule // codec_dsp_port_model

/* File: test/codec_dac_load_timing_tb.sv */
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (b)); end end

module codec_dac_load_timing_tb;
  import codec_dac_load_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        i_clk = 1'b0;
  logic        i_nrst = 1'b0;
  logic        i_ce = 1'b1;
  logic        sclk, sdi, ifs;
  logic        i_adc_valid = 1'b0;
  logic [15:0] i_adc_data = 16'h0000;
  logic [3:0]  i_dac_advance = 4'h0;
  logic        i_mixed_mode = 1'b0;
  logic [2:0]  i_device_count = 3'h0;
  logic [7:0]  i_readback_data = 8'h00;
  logic        serial_data_out, ofs, dac_load, ctrl_valid;
  logic [15:0] dac_value, ctrl_word;
  logic [2:0]  rb_sel;
  int          miscompares = 0;
  int          checks = 0;
  int          ctrl_cnt = 0;

  always #20 i_clk = ~i_clk;
  always @(posedge i_clk) if (ctrl_valid === 1'b1) ctrl_cnt++;

  codec_dsp_port_model u_codec_dsp_port_model (.o_sclk(sclk), .o_sdi(sdi),
    .o_ifs(ifs), .i_sdo(serial_data_out), .i_ofs(ofs));

  codec_dac_load_timing u_codec_dac_load_timing (.i_clk(i_clk),
    .i_nrst(i_nrst), .i_ce(i_ce), .i_sclk(sclk), .i_sdi(sdi),
    .i_input_frame_sync(ifs), .i_adc_valid(i_adc_valid),
    .i_adc_data(i_adc_data), .i_dac_advance(i_dac_advance),
    .i_mixed_mode(i_mixed_mode), .i_device_count(i_device_count),
    .i_readback_data(i_readback_data), .o_serial_data_out(serial_data_out),
    .o_output_frame_sync(ofs), .o_dac_load(dac_load),
    .o_dac_value(dac_value), .o_ctrl_valid(ctrl_valid),
    .o_ctrl_word(ctrl_word), .o_readback_sel(rb_sel));

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic stop_test;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic send(input logic [15:0] w);
    u_codec_dsp_port_model.send(w);
    repeat (10) @(posedge i_clk);
  endtask

  task automatic wait_rx(input int c0, input logic [15:0] exp);
    int n;
    n = 0;
    while (u_codec_dsp_port_model.rx_cnt == c0 && n < 3000) begin
      @(posedge i_clk);
      n++;
    end
    `CHK(u_codec_dsp_port_model.rx_word, exp)
  endtask

  task automatic adc_unload(input logic [15:0] d, input logic [3:0] adv,
                            input logic [15:0] dac);
    int n;
    int c0;
    c0 = u_codec_dsp_port_model.rx_cnt;
    @(posedge i_clk);
    i_dac_advance <= adv;
    i_adc_data <= d;
    i_adc_valid <= 1'b1;
    @(posedge i_clk);
    i_adc_valid <= 1'b0;
    #1;
    n = 0;
    while (dac_load !== 1'b1 && n < 40) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    `CHK(5'(n), ADV_SPAN - {1'b0, adv})
    `CHK(dac_value, dac)
    `CHK(ofs, 1'b0)
    wait_rx(c0, d);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_default_load;
    send(16'h1234);
    adc_unload(16'hA5C3, 4'h0, 16'h1234);
    $display("test default_load done");
  endtask

  task automatic t_advance;
    adc_unload(16'h3C5A, 4'hF, 16'h1234);
    adc_unload(16'hC3A5, 4'h5, 16'h1234);
    $display("test advance done");
  endtask

  task automatic t_mixed;
    int c0;
    i_mixed_mode <= 1'b1;
    c0 = ctrl_cnt;
    send(16'h8055);
    `CHK(ctrl_cnt, c0 + 1)
    `CHK(ctrl_word, 16'h8055)
    send(16'h7FFF);
    adc_unload(16'h0F0F, 4'h0, 16'h7FFF);
    $display("test mixed done");
  endtask

  task automatic t_forward;
    int c0;
    int k0;
    c0 = u_codec_dsp_port_model.rx_cnt;
    k0 = ctrl_cnt;
    send(16'h8855);
    wait_rx(c0, 16'h8055);
    `CHK(ctrl_cnt, k0)
    $display("test forward done");
  endtask

  task automatic t_readback;
    int c0;
    c0 = u_codec_dsp_port_model.rx_cnt;
    i_readback_data <= 8'h5A;
    send(16'hC2AA);
    `CHK(rb_sel, 3'h2)
    wait_rx(c0, 16'hFA5A);
    $display("test readback done");
  endtask

  task automatic t_cascade;
    i_mixed_mode <= 1'b0;
    i_device_count <= 3'h1;
    send(16'h1111);
    send(16'h2222);
    adc_unload(16'h5555, 4'h0, 16'h2222);
    $display("test cascade done");
  endtask

  // Clock enable low holds the countdown; it resumes where it stopped
  task automatic t_freeze;
    int n;
    int c0;
    repeat (20) @(posedge i_clk);
    c0 = u_codec_dsp_port_model.rx_cnt;
    @(posedge i_clk);
    i_dac_advance <= 4'h0;
    i_adc_data <= 16'h6996;
    i_adc_valid <= 1'b1;
    @(posedge i_clk);
    i_adc_valid <= 1'b0;
    i_ce <= 1'b0;
    n = 0;
    repeat (24) begin
      @(posedge i_clk);
      #1;
      if (dac_load !== 1'b0) n++;
    end
    `CHK(n, 0)
    @(posedge i_clk);
    i_ce <= 1'b1;
    #1;
    n = 0;
    while (dac_load !== 1'b1 && n < 40) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    `CHK(5'(n), ADV_SPAN)
    wait_rx(c0, 16'h6996);
    $display("test freeze done");
  endtask

  initial begin
    repeat (3) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (10) @(posedge i_clk);
    t_default_load();
    t_advance();
    t_mixed();
    t_forward();
    t_readback();
    t_cascade();
    t_freeze();
    stop_test();
  end

  initial begin
    #500000;
    miscompares++;
    stop_test();
  end
endmodule // codec_dac_load_timing_tb
